/* hw/serial_register_slave_frames.sv */
// command interpreter for framed serial register access: read, loopback, multi write
`timescale 1ns/1ps
module serial_register_slave_frames #(
   parameter int MAX_CMD_BYTES = slave_frames_pkg::MAX_CMD
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire slave_frames_pkg::rx_byte_t rx_in,
   input wire logic [7:0] own_addr,
   input wire logic comm_enter_function_select,
   input wire logic [15:0] reg_rdata,
   input wire logic tx_ready,
   output logic tx_valid,
   output logic [7:0] tx_data,
   output slave_frames_pkg::reg_req_t reg_req,
   output logic frame_busy
);
   generate
      if (MAX_CMD_BYTES < slave_frames_pkg::MAX_CMD || MAX_CMD_BYTES > 63) begin : g_bad_len
         $error("command buffer must hold 41 to 63 bytes");
      end
   endgenerate

   typedef enum {S_CLR, S_RX, S_DEC, S_WR, S_HDR, S_RD_REQ, S_RD_WAIT, S_RD_CAP,
                 S_RD_HI, S_RD_LO, S_CRC_LO, S_CRC_HI} state_t;
   typedef enum {R_LOOP, R_EXC, R_WR, R_RD} resp_t;

   state_t state_reg, state_next;
   resp_t resp_reg, resp_next;
   logic [7:0] buf_reg [MAX_CMD_BYTES];
   logic [7:0] buf_next [MAX_CMD_BYTES];
   logic [5:0] len_reg, len_next, idx_reg, idx_next;
   logic [15:0] crc_reg, crc_next, txcrc_reg, txcrc_next, word_reg, word_next;
   logic ovf_reg, ovf_next, busy_reg, busy_next;
   logic [7:0] code_reg, code_next;
   slave_frames_pkg::reg_req_t req_reg, req_next;
   logic push;
   logic [7:0] push_data;
   logic fifo_in_ready;

   // frame fields
   logic [7:0] fc;
   logic [15:0] start, qty;
   logic bcast, frame_ok, qty_ok, wr_ok, fix_len;
   logic [5:0] data_pos, hdr_last;
   logic [7:0] hdr_byte;

   assign fc = buf_reg[1];
   assign start = {buf_reg[2], buf_reg[3]};
   assign qty = {buf_reg[4], buf_reg[5]};
   assign bcast = (buf_reg[0] == slave_frames_pkg::BCAST_ADDR);
   // accept only complete, uncorrupted frames for this node; a good frame leaves a zero residue
   assign frame_ok = !ovf_reg && (len_reg >= 6'(slave_frames_pkg::MIN_FRAME)) && (crc_reg == 16'h0000)
                     && (bcast || buf_reg[0] == own_addr);
   assign qty_ok = (qty != 16'h0000) && (qty <= 16'(slave_frames_pkg::MAX_REGS));
   assign fix_len = (len_reg == 6'(slave_frames_pkg::FIX_CMD_LEN));
   // byte count must match quantity, and frame length must match byte count
   assign wr_ok = qty_ok && (buf_reg[slave_frames_pkg::WR_CNT_POS] == {qty[6:0], 1'b0})
                  && (len_reg == 6'(slave_frames_pkg::WR_DATA_POS + 2) + {qty[4:0], 1'b0});
   assign data_pos = 6'(slave_frames_pkg::WR_DATA_POS) + {idx_reg[4:0], 1'b0};

   // header byte of the reply being built
   always_comb begin
      hdr_byte = buf_reg[idx_reg];
      hdr_last = 6'(slave_frames_pkg::SHORT_HDR_LAST);
      case (resp_reg)
         R_EXC: begin
            if (idx_reg == 6'h01) begin
               hdr_byte = fc | slave_frames_pkg::EXC_FLAG;
            end else if (idx_reg != 6'h00) begin
               hdr_byte = code_reg;
            end
         end
         R_RD: begin
            if (idx_reg == 6'h02) begin
               hdr_byte = {qty[6:0], 1'b0};
            end
         end
         R_WR: hdr_last = 6'(slave_frames_pkg::WR_RESP_LAST);
         default: hdr_last = len_reg - 6'h01;
      endcase
   end

   // command sequencer next values
   always_comb begin
      state_next = state_reg;
      resp_next = resp_reg;
      buf_next = buf_reg;
      len_next = len_reg;
      idx_next = idx_reg;
      crc_next = crc_reg;
      txcrc_next = txcrc_reg;
      word_next = word_reg;
      ovf_next = ovf_reg;
      code_next = code_reg;
      req_next = '0;
      push = 1'b0;
      push_data = 8'h00;
      case (state_reg)
         S_CLR: begin
            len_next = '0;
            crc_next = slave_frames_pkg::CRC_INIT;
            ovf_next = 1'b0;
            state_next = S_RX;
         end
         S_RX: begin
            if (rx_in.valid) begin
               if (len_reg < 6'(MAX_CMD_BYTES)) begin
                  buf_next[len_reg] = rx_in.data;
                  len_next = len_reg + 6'h01;
                  crc_next = slave_frames_pkg::crc_step(crc_reg, rx_in.data);
               end else begin
                  ovf_next = 1'b1;
               end
            end
            if (rx_in.frame_end) begin
               state_next = S_DEC;
            end
         end
         S_DEC: begin
            idx_next = '0;
            txcrc_next = slave_frames_pkg::CRC_INIT;
            resp_next = R_EXC;
            code_next = slave_frames_pkg::ERR_DATA;
            state_next = bcast ? S_CLR : S_HDR;
            if (!frame_ok) begin
               state_next = S_CLR;
            end else if (fc == slave_frames_pkg::FC_READ) begin
               if (fix_len && qty_ok) begin
                  resp_next = R_RD;
               end
            end else if (fc == slave_frames_pkg::FC_LOOP) begin
               if (fix_len) begin
                  resp_next = R_LOOP;
               end
            end else if (fc == slave_frames_pkg::FC_WRITE) begin
               if (wr_ok) begin
                  state_next = S_WR;
               end
            end else begin
               code_next = slave_frames_pkg::ERR_FUNC;
            end
         end
         S_WR: begin
            req_next.valid = 1'b1;
            req_next.we = 1'b1;
            req_next.stage = comm_enter_function_select;
            req_next.addr = start + {10'h000, idx_reg};
            req_next.wdata = {buf_reg[data_pos], buf_reg[data_pos + 6'h01]};
            idx_next = idx_reg + 6'h01;
            if ({10'h000, idx_reg} == qty - 16'h0001) begin
               idx_next = '0;
               resp_next = R_WR;
               state_next = bcast ? S_CLR : S_HDR;
            end
         end
         S_HDR: begin
            if (fifo_in_ready) begin
               push = 1'b1;
               push_data = hdr_byte;
               txcrc_next = slave_frames_pkg::crc_step(txcrc_reg, hdr_byte);
               idx_next = idx_reg + 6'h01;
               if (idx_reg == hdr_last) begin
                  idx_next = '0;
                  if (resp_reg == R_LOOP) begin
                     state_next = S_CLR;
                  end else if (resp_reg == R_RD) begin
                     state_next = S_RD_REQ;
                  end else begin
                     state_next = S_CRC_LO;
                  end
               end
            end
         end
         S_RD_REQ: begin
            req_next.valid = 1'b1;
            req_next.addr = start + {10'h000, idx_reg};
            state_next = S_RD_WAIT;
         end
         S_RD_WAIT: state_next = S_RD_CAP;
         S_RD_CAP: begin
            word_next = reg_rdata;
            state_next = S_RD_HI;
         end
         S_RD_HI: begin
            if (fifo_in_ready) begin
               push = 1'b1;
               push_data = word_reg[15:8];
               txcrc_next = slave_frames_pkg::crc_step(txcrc_reg, word_reg[15:8]);
               state_next = S_RD_LO;
            end
         end
         S_RD_LO: begin
            if (fifo_in_ready) begin
               push = 1'b1;
               push_data = word_reg[7:0];
               txcrc_next = slave_frames_pkg::crc_step(txcrc_reg, word_reg[7:0]);
               idx_next = idx_reg + 6'h01;
               state_next = ({10'h000, idx_reg} == qty - 16'h0001) ? S_CRC_LO : S_RD_REQ;
            end
         end
         S_CRC_LO: begin
            if (fifo_in_ready) begin
               push = 1'b1;
               push_data = txcrc_reg[7:0];
               state_next = S_CRC_HI;
            end
         end
         default: begin
            if (fifo_in_ready) begin
               push = 1'b1;
               push_data = txcrc_reg[15:8];
               state_next = S_CLR;
            end
         end
      endcase
      // a broadcast write leaves for clear while its last access still shows, so that access holds busy up
      busy_next = ((state_next != S_RX) && (state_next != S_CLR)) || req_next.valid;
   end

   // registers only
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= S_CLR;
         resp_reg <= R_EXC;
         buf_reg <= '{default: 8'h00};
         len_reg <= '0;
         idx_reg <= '0;
         crc_reg <= slave_frames_pkg::CRC_INIT;
         txcrc_reg <= slave_frames_pkg::CRC_INIT;
         word_reg <= '0;
         ovf_reg <= 1'b0;
         code_reg <= 8'h00;
         req_reg <= '0;
         busy_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         resp_reg <= resp_next;
         buf_reg <= buf_next;
         len_reg <= len_next;
         idx_reg <= idx_next;
         crc_reg <= crc_next;
         txcrc_reg <= txcrc_next;
         word_reg <= word_next;
         ovf_reg <= ovf_next;
         code_reg <= code_next;
         req_reg <= req_next;
         busy_reg <= busy_next;
      end
   end

   assign reg_req = req_reg;
   assign frame_busy = busy_reg;

   // reply bytes queue toward the line layer; a full queue stalls the sequencer
   byte_fifo #(.WIDTH(8), .DEPTH(slave_frames_pkg::FIFO_DEPTH)) u_tx_fifo (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .in_valid(push),
      .in_ready(fifo_in_ready),
      .in_data(push_data),
      .out_valid(tx_valid),
      .out_ready(tx_ready),
      .out_data(tx_data)
   );
endmodule

/* include/slave_frames_pkg.sv */
// shared constants, carriers and the frame check function for the serial register slave
package slave_frames_pkg;
   // function codes and exception encoding
   localparam logic [7:0] FC_READ = 8'h03;
   localparam logic [7:0] FC_LOOP = 8'h08;
   localparam logic [7:0] FC_WRITE = 8'h10;
   localparam logic [7:0] EXC_FLAG = 8'h80;
   localparam logic [7:0] ERR_FUNC = 8'h01;
   localparam logic [7:0] ERR_DATA = 8'h03;
   localparam logic [7:0] BCAST_ADDR = 8'h00;
   // frame check
   localparam logic [15:0] CRC_INIT = 16'hffff;
   localparam logic [15:0] CRC_POLY = 16'ha001;
   // frame geometry in bytes
   localparam int MAX_REGS = 16;
   localparam int MAX_CMD = 41;
   localparam int FIX_CMD_LEN = 8;
   localparam int MIN_FRAME = 4;
   localparam int WR_DATA_POS = 7;
   localparam int WR_CNT_POS = 6;
   localparam int WR_RESP_LAST = 5;
   localparam int SHORT_HDR_LAST = 2;
   localparam int FIFO_DEPTH = 16;

   // one received byte, with the end-of-frame gap marker from the line layer
   typedef struct packed {
      logic valid;
      logic frame_end;
      logic [7:0] data;
   } rx_byte_t;

   // one register access toward the register file
   typedef struct packed {
      logic valid;
      logic we;
      logic stage;
      logic [15:0] addr;
      logic [15:0] wdata;
   } reg_req_t;

   // one byte through the right-shifting reflected check
   function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [7:0] b);
      logic [15:0] c;
      c = crc ^ {8'h00, b};
      for (int i = 0; i < 8; i++) begin
         c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
      end
      return c;
   endfunction
endpackage

/* hw/byte_fifo.sv */
// fifo with a registered output stage
`timescale 1ns/1ps
module byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = slave_frames_pkg::FIFO_DEPTH
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   generate
      if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
         $error("byte_fifo depth must be a power of two, at least 2");
      end
   endgenerate

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [WIDTH-1:0] mem_next [DEPTH];
   logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
   logic [AW:0] cnt_reg, cnt_next;
   logic ov_reg, ov_next;
   logic [WIDTH-1:0] od_reg, od_next;
   logic push, pop, load;

   assign in_ready = (cnt_reg != (AW+1)'(DEPTH));
   assign out_valid = ov_reg;
   assign out_data = od_reg;

   // storage and output stage next values; the output refills when empty or taken
   always_comb begin
      mem_next = mem_reg;
      load = !ov_reg || out_ready;
      push = in_valid && in_ready;
      pop = load && (cnt_reg != '0);
      wp_next = push ? wp_reg + 1'b1 : wp_reg;
      rp_next = pop ? rp_reg + 1'b1 : rp_reg;
      if (push) begin
         mem_next[wp_reg] = in_data;
      end
      cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
      ov_next = load ? (cnt_reg != '0) : ov_reg;
      od_next = pop ? mem_reg[rp_reg] : od_reg;
   end

   // registers only
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         mem_reg <= '{default: '0};
         wp_reg <= '0;
         rp_reg <= '0;
         cnt_reg <= '0;
         ov_reg <= 1'b0;
         od_reg <= '0;
      end else begin
         mem_reg <= mem_next;
         wp_reg <= wp_next;
         rp_reg <= rp_next;
         cnt_reg <= cnt_next;
         ov_reg <= ov_next;
         od_reg <= od_next;
      end
   end
endmodule

/* verif/frames_checker.sv */
// port-level assertions for the serial register slave
`timescale 1ns/1ps
module frames_checker #(
   parameter int MAX_CMD_BYTES = slave_frames_pkg::MAX_CMD
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire slave_frames_pkg::rx_byte_t rx_in,
   input wire logic [7:0] own_addr,
   input wire logic comm_enter_function_select,
   input wire logic [15:0] reg_rdata,
   input wire logic tx_ready,
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   input wire slave_frames_pkg::reg_req_t reg_req,
   input wire logic frame_busy
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   logic wr_now;
   logic rd_now;
   logic [5:0] wr_run_reg;
   logic [5:0] rd_cnt_reg;
   assign wr_now = reg_req.valid && reg_req.we;
   assign rd_now = reg_req.valid && !reg_req.we;
   // back-to-back write run and reads in the current frame
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_run_reg <= 6'h00;
         rd_cnt_reg <= 6'h00;
      end else begin
         wr_run_reg <= wr_now ? wr_run_reg + 6'h01 : 6'h00;
         rd_cnt_reg <= frame_busy ? rd_cnt_reg + 6'(rd_now) : 6'h00;
      end
   end
   sequence wr_s;
      reg_req.valid && reg_req.we;
   endsequence
   sequence rd_s;
      reg_req.valid && !reg_req.we;
   endsequence
   chk_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
      else $error("stalled reply byte changed");
   chk_wr_ascend: assert property (wr_s ##1 wr_s |-> reg_req.addr == $past(reg_req.addr) + 16'h0001)
      else $error("write address not consecutive");
   chk_wr_stage: assert property (wr_now && $stable(comm_enter_function_select) |->
      reg_req.stage == comm_enter_function_select) else $error("stage bit differs from select");
   chk_stage_steady: assert property (wr_s ##1 wr_s |-> $stable(reg_req.stage))
      else $error("stage bit changed within a write");
   chk_rd_spacing: assert property (rd_s |=> !reg_req.valid [*4])
      else $error("reads too close");
   chk_req_busy: assert property (reg_req.valid |-> frame_busy)
      else $error("register access outside a frame");
   chk_wr_max_run: assert property (wr_run_reg <= 6'h10)
      else $error("more than sixteen writes");
   chk_rd_max_count: assert property (rd_cnt_reg <= 6'h10)
      else $error("more than sixteen reads");
endmodule
bind serial_register_slave_frames frames_checker #(.MAX_CMD_BYTES(MAX_CMD_BYTES)) chk (.ref_clk(ref_clk),
   .rst_n(rst_n), .rx_in(rx_in), .own_addr(own_addr), .comm_enter_function_select(comm_enter_function_select),
   .reg_rdata(reg_rdata), .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .reg_req(reg_req),
   .frame_busy(frame_busy));

/* verif/line_master.sv */
// serial master model: sends frames, takes reply bytes with random stalls
`timescale 1ns/1ps
module line_master (
   input wire logic ref_clk,
   output slave_frames_pkg::rx_byte_t rx_in,
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   output logic tx_ready
);
   logic [7:0] got[$];
   initial begin
      rx_in = '0;
      tx_ready = 1'b0;
   end
   // reply bytes kept in arrival order, sink stalls one cycle in four
   always @(posedge ref_clk) begin
      if (tx_valid && tx_ready) got.push_back(tx_data);
      tx_ready <= ($urandom % 4) != 0;
   end
   // one byte a cycle, gap marker on the last; idle data shows the inverse
   task automatic send(input logic [7:0] f[$]);
      foreach (f[i]) begin
         @(posedge ref_clk);
         rx_in <= '{1'b1, i == f.size() - 1, f[i]};
      end
      @(posedge ref_clk);
      rx_in <= '{1'b0, 1'b0, ~f[f.size() - 1]};
   endtask
endmodule

/* verif/serial_register_slave_frames_test.sv */
// self-checking bench for the serial register slave
`timescale 1ns/1ps
module serial_register_slave_frames_test;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] own_addr = 8'h01;
   logic comm_enter_function_select = 1'b0;
   logic [15:0] reg_rdata = 16'h0000;
   logic tx_ready;
   logic tx_valid;
   logic frame_busy;
   logic [7:0] tx_data;
   slave_frames_pkg::rx_byte_t rx_in;
   slave_frames_pkg::reg_req_t reg_req;
   logic [7:0] fr[$];
   logic [7:0] rsp[$];
   logic [32:0] ew[$];
   logic [32:0] wr_log[$];
   int err_count = 0;
   int checked = 0;
   always #5 ref_clk = ~ref_clk;
   serial_register_slave_frames dut (.ref_clk(ref_clk), .rst_n(rst_n), .rx_in(rx_in), .own_addr(own_addr),
      .comm_enter_function_select(comm_enter_function_select), .reg_rdata(reg_rdata), .tx_ready(tx_ready),
      .tx_valid(tx_valid), .tx_data(tx_data), .reg_req(reg_req), .frame_busy(frame_busy));
   line_master master (.ref_clk(ref_clk), .rx_in(rx_in), .tx_valid(tx_valid), .tx_data(tx_data),
      .tx_ready(tx_ready));
   function automatic logic [15:0] rd_word(input logic [15:0] a);
      return {a[7:0] ^ 8'h3c, a[15:8] ^ 8'ha5};
   endfunction
   function automatic logic [15:0] crc16(input logic [7:0] f[$]);
      logic [15:0] c;
      c = 16'hffff;
      foreach (f[i]) begin
         c ^= {8'h00, f[i]};
         repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
      end
      return c;
   endfunction
   // register file stand-in: word in the cycle after a read, noise otherwise
   always @(posedge ref_clk) begin
      reg_rdata <= (reg_req.valid && !reg_req.we) ? rd_word(reg_req.addr) : 16'($urandom);
      if (reg_req.valid && reg_req.we) wr_log.push_back(reg_req[32:0]);
   end
   task automatic tick();
      @(posedge ref_clk);
      #1;
   endtask
   task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
      checked++;
      if (g !== e) begin
         err_count++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic cmp33(input logic [32:0] g, input logic [32:0] e);
      checked++;
      if (g !== e) begin
         err_count++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic p16(ref logic [7:0] f[$], input logic [15:0] v);
      f.push_back(v[15:8]);
      f.push_back(v[7:0]);
   endtask
   task automatic seal(ref logic [7:0] f[$]);
      logic [15:0] c;
      c = crc16(f);
      f.push_back(c[7:0]);
      f.push_back(c[15:8]);
   endtask
   task automatic exc(input logic [7:0] a, input logic [7:0] fc, input logic [7:0] code);
      rsp = {a, fc, code};
      seal(rsp);
   endtask
   // send one frame, wait for the answer to drain, compare reply and writes
   task automatic run();
      int n;
      master.got.delete();
      wr_log.delete();
      master.send(fr);
      n = 0;
      repeat (3) tick();
      while ((frame_busy !== 1'b0 || tx_valid !== 1'b0) && n < 3000) begin
         tick();
         n++;
      end
      tick();
      cmp8(8'(n / 3000), 8'h00);
      cmp8(8'(master.got.size()), 8'(rsp.size()));
      foreach (rsp[i]) cmp8(master.got[i], rsp[i]);
      cmp8(8'(wr_log.size()), 8'(ew.size()));
      foreach (ew[i]) cmp33(wr_log[i], ew[i]);
   endtask
   task automatic end_sim();
      $display("checked %0d err_count %0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      logic [7:0] a;
      logic [15:0] st;
      logic [15:0] q;
      logic s;
      int k;
      void'($urandom(79507));
      repeat (12) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge ref_clk);
      fr = {8'h01, 8'h08, 8'h00, 8'h00, 8'ha5, 8'h37, 8'hda, 8'h8d};
      rsp = fr;
      ew = {};
      run();
      for (int t = 0; t < 32; t++) begin
         if (t == 16) begin
            @(posedge ref_clk);
            rst_n <= 1'b0;
            tick();
            cmp8({6'h00, tx_valid | reg_req.valid, frame_busy}, 8'h00);
            @(posedge ref_clk);
            rst_n <= 1'b1;
            repeat (3) @(posedge ref_clk);
         end
         k = t % 8;
         a = 8'($urandom_range(1, 247));
         s = 1'($urandom);
         q = (k == 1) ? ((t < 8) ? 16'h0000 : 16'h0011) : ((t < 8) ? 16'h0010 : 16'($urandom_range(1, 16)));
         st = 16'($urandom_range(0, 16'hffe0));
         @(posedge ref_clk);
         own_addr <= a;
         comm_enter_function_select <= s;
         fr = {a, 8'h03};
         rsp = {};
         ew = {};
         case (k)
            0, 1: begin
               p16(fr, st);
               p16(fr, q);
               if (k == 1) exc(a, 8'h83, 8'h03);
               else begin
                  rsp = {a, 8'h03, 8'(2 * q)};
                  for (int i = 0; i < q; i++) p16(rsp, rd_word(st + 16'(i)));
                  seal(rsp);
               end
            end
            2, 5: begin
               fr[0] = (k == 5 && t < 8) ? ~a : a;
               fr[1] = 8'h08;
               p16(fr, 16'($urandom));
               p16(fr, 16'($urandom));
               // late corner cases: a loopback one word too long, and a frame past the buffer
               if (k == 2 && t >= 24) p16(fr, 16'($urandom));
               if (k == 5 && t >= 24) repeat (36) fr.push_back(8'($urandom));
            end
            3, 4, 6: begin
               fr[0] = (k == 6) ? 8'h00 : a;
               fr[1] = 8'h10;
               p16(fr, st);
               p16(fr, q);
               fr.push_back(8'(2 * q) + 8'(k == 4));
               for (int i = 0; i < q; i++) begin
                  ew.push_back({s, st + 16'(i), 16'($urandom)});
                  p16(fr, ew[i][15:0]);
               end
               if (k == 4) ew = {};
               if (k == 4) exc(a, 8'h90, 8'h03);
               if (k == 3) rsp = fr[0:5];
               if (k == 3) seal(rsp);
            end
            default: begin
               fr[1] = 8'h04 + 8'(t);
               p16(fr, st);
               p16(fr, q);
               exc(a, fr[1] | 8'h80, 8'h01);
            end
         endcase
         seal(fr);
         if (k == 5 && t >= 8 && t < 24) fr[7] = ~fr[7];
         if (k == 2 && t < 24) rsp = fr;
         if (k == 2 && t >= 24) exc(a, 8'h88, 8'h03);
         run();
      end
      end_sim();
   end
   initial begin
      repeat (80000) @(posedge ref_clk);
      err_count++;
      end_sim();
   end
endmodule
